// ---- core/scs_defs.svh ----
// What this block does
// - Serial management port acts only as slave
// - Master reads and writes every read/write register
// - Read-only and preloaded bytes writable from port
// - Clock and data lines are open-drain two-way
// - Three straps give address bits zero to two
// - Upper address bits fixed, range 0x68 to 0x6F
// - Bytes 8 to 11: writing one clears bit, zero keeps it
// - Sticky bytes survive ordinary reset, cleared by power-on
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH

`define SCS_ADDR_HI 4'hD
`define SCS_NUM_BYTES 16
`define SCS_REG_RST 8'h00
`define SCS_CLK_NS 50
`define SCS_STRETCH_NS 500
`define SCS_STRETCH_CYC ((`SCS_STRETCH_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS)

`endif

// ---- core/scs_pkg.sv ----
package scs_pkg;

	typedef enum {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_OFFS, ST_OFFS_ACK,
		ST_WDATA, ST_WDATA_ACK, ST_STRETCH, ST_RDATA, ST_RACK
	} scs_state_t;

	typedef enum {
		BT_RW, BT_HWINIT, BT_W1C, BT_STICKY_W1C, BT_STICKY_RW, BT_STICKY_RO
	} scs_byte_type_t;

	typedef struct packed {
		logic scl_o;
		logic scl_oe_n;
		logic sda_o;
		logic sda_oe_n;
	} scs_pins_t;

	// Fixed access type of each byte of the register space
	function automatic scs_byte_type_t byte_type(input logic [3:0] idx);
		case (idx[3:1])
			3'h0, 3'h1: byte_type = BT_RW;
			3'h2, 3'h3: byte_type = BT_HWINIT;
			3'h4: byte_type = BT_W1C;
			3'h5: byte_type = BT_STICKY_W1C;
			3'h6: byte_type = BT_STICKY_RW;
			default: byte_type = BT_STICKY_RO;
		endcase
	endfunction

endpackage

// ---- core/scs_slave.sv ----
`timescale 1ns/1ps
`include "scs_defs.svh"

module scs_slave (
	input wire logic clk,
	input wire logic srst,
	input wire logic por_rst,
	input wire logic ce,
	input wire logic [2:0] addr_strap,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic [31:0] clear_flag_set,
	output scs_pkg::scs_pins_t pins,
	output logic [`SCS_NUM_BYTES*8-1:0] cfg_bytes
);

	typedef struct packed {
		logic [1:0] scl_s;
		logic scl_p;
		logic [1:0] sda_s;
		logic sda_p;
		logic [5:0] strap_s;
		logic [2:0] addr_lo;
		scs_pkg::scs_state_t st;
		logic [3:0] bits;
		logic [7:0] sh;
		logic [7:0] offs;
		logic rnw;
		logic acked;
		logic [3:0] stretch;
		scs_pkg::scs_pins_t pins;
		logic [`SCS_NUM_BYTES-1:0][7:0] regs;
	} scs_core_t;

	localparam logic [3:0] STRETCH_CYC = 4'(`SCS_STRETCH_CYC);
	localparam logic [7:0] LAST_OFFS = 8'(`SCS_NUM_BYTES - 1);

	scs_core_t q;
	scs_core_t d;

	logic scl_now;
	logic sda_now;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic [7:0] rd_byte;
	logic [7:0] rd_next;

	function automatic logic [7:0] read_at(input scs_core_t s,
		input logic [7:0] o);
		read_at = (o <= LAST_OFFS) ? s.regs[o[3:0]] : 8'h00;
	endfunction

	////////////////////////////////////////////////////////////////////
	// Line conditions from the second synchroniser stage on

	always_comb begin
		scl_now = q.scl_s[1];
		sda_now = q.sda_s[1];
		scl_rise = scl_now && !q.scl_p;
		scl_fall = !scl_now && q.scl_p;
		start_c = scl_now && q.scl_p && q.sda_p && !sda_now;
		stop_c = scl_now && q.scl_p && !q.sda_p && sda_now;
		rd_byte = read_at(q, q.offs);
		rd_next = read_at(q, q.offs + 8'h01);
	end

	////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		d = q;
		if (ce) begin
			d.scl_s = {q.scl_s[0], scl_i};
			d.sda_s = {q.sda_s[0], sda_i};
			d.strap_s = {d.strap_s[2:0], addr_strap};
			d.scl_s[1] = q.scl_s[0];
			d.sda_s[1] = q.sda_s[0];
			d.strap_s[5:3] = q.strap_s[2:0];
			d.scl_p = scl_now;
			d.sda_p = sda_now;
			if (scl_rise)
				d.bits = q.bits + 4'h1;
			if (start_c) begin
				d.st = scs_pkg::ST_ADDR;
				d.bits = 4'h0;
				d.pins.sda_oe_n = 1'b1;
			end else if (stop_c) begin
				d.st = scs_pkg::ST_IDLE;
				d.pins.sda_oe_n = 1'b1;
			end else begin
				case (q.st)
				scs_pkg::ST_IDLE: begin
					d.pins.sda_oe_n = 1'b1;
					d.pins.scl_oe_n = 1'b1;
				end
				scs_pkg::ST_ADDR, scs_pkg::ST_OFFS, scs_pkg::ST_WDATA: begin
					if (scl_rise)
						d.sh = {q.sh[6:0], sda_now};
					if (scl_fall && q.bits == 4'h8) begin
						d.bits = 4'h0;
						d.pins.sda_oe_n = 1'b0;
						if (q.st == scs_pkg::ST_ADDR) begin
							if (q.sh[7:1] == {`SCS_ADDR_HI, q.addr_lo}) begin
								d.rnw = q.sh[0];
								d.st = scs_pkg::ST_ADDR_ACK;
							end else begin
								d.pins.sda_oe_n = 1'b1;
								d.st = scs_pkg::ST_IDLE;
							end
						end else if (q.st == scs_pkg::ST_OFFS) begin
							d.offs = q.sh;
							d.st = scs_pkg::ST_OFFS_ACK;
						end else begin
							if (q.offs <= LAST_OFFS) begin
								case (scs_pkg::byte_type(q.offs[3:0]))
								scs_pkg::BT_W1C, scs_pkg::BT_STICKY_W1C:
									d.regs[q.offs[3:0]] =
										q.regs[q.offs[3:0]] & ~q.sh;
								default:
									d.regs[q.offs[3:0]] = q.sh;
								endcase
							end
							d.st = scs_pkg::ST_WDATA_ACK;
						end
					end
				end
				scs_pkg::ST_ADDR_ACK: begin
					if (scl_fall) begin
						d.bits = 4'h0;
						if (q.rnw) begin
							d.sh = rd_byte;
							d.pins.sda_oe_n = rd_byte[7];
							d.st = scs_pkg::ST_RDATA;
						end else begin
							d.pins.sda_oe_n = 1'b1;
							d.st = scs_pkg::ST_OFFS;
						end
					end
				end
				scs_pkg::ST_OFFS_ACK: begin
					if (scl_fall) begin
						d.bits = 4'h0;
						d.pins.sda_oe_n = 1'b1;
						d.st = scs_pkg::ST_WDATA;
					end
				end
				scs_pkg::ST_WDATA_ACK: begin
					if (scl_fall) begin
						d.bits = 4'h0;
						d.pins.sda_oe_n = 1'b1;
						d.offs = q.offs + 8'h01;
						d.pins.scl_oe_n = 1'b0;
						d.stretch = STRETCH_CYC;
						d.st = scs_pkg::ST_STRETCH;
					end
				end
				scs_pkg::ST_STRETCH: begin
					d.bits = 4'h0;
					if (q.stretch == 4'h1) begin
						d.pins.scl_oe_n = 1'b1;
						d.st = scs_pkg::ST_WDATA;
					end
					d.stretch = q.stretch - 4'h1;
				end
				scs_pkg::ST_RDATA: begin
					if (scl_fall) begin
						if (q.bits == 4'h8) begin
							d.bits = 4'h0;
							d.pins.sda_oe_n = 1'b1;
							d.st = scs_pkg::ST_RACK;
						end else begin
							d.sh = {q.sh[6:0], 1'b0};
							d.pins.sda_oe_n = q.sh[6];
						end
					end
				end
				scs_pkg::ST_RACK: begin
					if (scl_rise)
						d.acked = !sda_now;
					if (scl_fall) begin
						d.bits = 4'h0;
						if (q.acked) begin
							d.offs = q.offs + 8'h01;
							d.sh = rd_next;
							d.pins.sda_oe_n = rd_next[7];
							d.st = scs_pkg::ST_RDATA;
						end else begin
							d.st = scs_pkg::ST_IDLE;
						end
					end
				end
				default: d.st = scs_pkg::ST_IDLE;
				endcase
			end
			// Hardware events set clear-on-write bits; set beats clear
			for (int i = 0; i < 32; i++) begin
				if (clear_flag_set[i])
					d.regs[8 + i / 8][i % 8] = 1'b1;
			end
		end
		if (srst || por_rst) begin
			d.addr_lo = q.strap_s[5:3];
			d.st = scs_pkg::ST_IDLE;
			d.bits = 4'h0;
			d.sh = 8'h00;
			d.offs = 8'h00;
			d.rnw = 1'b0;
			d.acked = 1'b0;
			d.stretch = 4'h0;
			d.pins = '{scl_o: 1'b0, scl_oe_n: 1'b1, sda_o: 1'b0,
				sda_oe_n: 1'b1};
			for (int b = 0; b < `SCS_NUM_BYTES; b++) begin
				case (scs_pkg::byte_type(4'(b)))
				scs_pkg::BT_STICKY_W1C, scs_pkg::BT_STICKY_RW,
				scs_pkg::BT_STICKY_RO: begin
					if (por_rst)
						d.regs[b] = `SCS_REG_RST;
				end
				default: d.regs[b] = `SCS_REG_RST;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk) begin
		q <= d;
	end

	always_comb begin
		pins = q.pins;
		cfg_bytes = q.regs;
	end

endmodule

// ---- verification/scs_slave_assertions.sv ----
`timescale 1ns/1ps
`include "scs_defs.svh"
module scs_slave_chk (
	input wire logic clk,
	input wire logic srst,
	input wire logic por_rst,
	input wire logic scl_i,
	input wire scs_pkg::scs_pins_t pins,
	input wire logic [`SCS_NUM_BYTES*8-1:0] cfg_bytes
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst || por_rst);
	a_pins_open_drain: assert property (!pins.scl_o && !pins.sda_o)
		else $error("pin output not low");
	a_rst_plain_zero: assert property (disable iff (1'b0)
		srst |=> cfg_bytes[63:0] == '0) else $error("plain byte kept");
	a_sticky_kept: assert property (disable iff (por_rst)
		srst |=> $stable(cfg_bytes[127:80])) else $error("sticky lost");
	a_por_zero: assert property (disable iff (1'b0)
		por_rst |=> cfg_bytes[127:96] == '0) else $error("por left data");
	a_rst_lines_free: assert property (disable iff (1'b0)
		srst || por_rst |=> pins.scl_oe_n && pins.sda_oe_n)
		else $error("line held after reset");
	a_sda_scl_low: assert property ($changed(pins.sda_oe_n) |->
		!$past(scl_i)) else $error("data moved, clock high");
	a_stretch_len: assert property ($fell(pins.scl_oe_n) |->
		##9 !pins.scl_oe_n ##1 pins.scl_oe_n) else $error("bad stretch");
	a_stretch_low: assert property ($fell(pins.scl_oe_n) |->
		!$past(scl_i)) else $error("stretch in high phase");
	a_cfg_scl_low: assert property ($changed(cfg_bytes[63:0]) |->
		!$past(scl_i)) else $error("write, clock high");
	cover property ($fell(pins.sda_oe_n));
	cover property ($fell(pins.scl_oe_n));
	cover property ($changed(cfg_bytes[127:80]));
endmodule
////////////////////////////////////////////////////////////////////////
bind scs_slave scs_slave_chk i_scs_slave_chk (.clk(clk), .srst(srst),
	.por_rst(por_rst), .scl_i(scl_i), .pins(pins), .cfg_bytes(cfg_bytes));

// ---- verification/scs_mst.sv ----
`timescale 1ns/1ps
module scs_mst (
	input wire logic clk,
	input wire logic scl_w,
	input wire logic sda_w,
	output logic scl_m,
	output logic sda_m,
	output logic [7:0] stalls
);
	initial begin
		scl_m = 1'b1;
		sda_m = 1'b1;
		stalls = 8'h00;
	end
	task automatic hp();
		repeat (4) @(posedge clk);
	endtask
	// Raise clock, wait out stretching, four cycles high
	task automatic up();
		scl_m <= 1'b1;
		for (int n = 0; n < 40 && !scl_w; n++) @(posedge clk);
		if (!scl_w)
			stalls <= stalls + 8'h01;
		repeat (3) @(posedge clk);
	endtask
	task automatic start();
		@(posedge clk);
		sda_m <= 1'b1;
		hp();
		up();
		sda_m <= 1'b0;
		hp();
		scl_m <= 1'b0;
	endtask
	task automatic stop();
		@(posedge clk);
		sda_m <= 1'b0;
		hp();
		up();
		sda_m <= 1'b1;
		hp();
	endtask
	// Nine bits, MSB first, last one the acknowledge
	task automatic bits(input logic [8:0] w, output logic [8:0] r);
		for (int i = 8; i >= 0; i--) begin
			@(posedge clk);
			sda_m <= w[i];
			repeat (3) @(posedge clk);
			up();
			r[i] = sda_w;
			scl_m <= 1'b0;
		end
	endtask
endmodule

// ---- verification/scs_slave_tb.sv ----
`timescale 1ns/1ps
module scs_slave_tb;
	logic clk, srst, por_rst, scl_m, sda_m, scl_w, sda_w;
	logic [2:0] strap, sa;
	logic [6:0] ad;
	logic [3:0] o;
	logic [7:0] d;
	logic [31:0] fset;
	logic [7:0] mem [16];
	logic [8:0] r;
	logic [127:0] cfg;
	logic ce;
	logic [3:0] oh;
	logic [7:0] rb, stalls;
	scs_pkg::scs_pins_t pins;
	int bad_count, n_tests;
	assign scl_w = scl_m & pins.scl_oe_n;
	assign sda_w = sda_m & pins.sda_oe_n;
	scs_slave i_scs_slave (.clk(clk), .srst(srst), .por_rst(por_rst),
		.ce(ce), .addr_strap(strap), .scl_i(scl_w), .sda_i(sda_w),
		.clear_flag_set(fset), .pins(pins), .cfg_bytes(cfg));
	scs_mst i_scs_mst (.clk(clk), .scl_w(scl_w), .sda_w(sda_w),
		.scl_m(scl_m), .sda_m(sda_m), .stalls(stalls));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic stop_test();
		$display("errors %0d checks %0d", bad_count, n_tests);
		if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [6:0] a);
		i_scs_mst.start();
		i_scs_mst.bits({a, 2'b01}, r);
		if (!r[0]) begin
			i_scs_mst.bits({oh, o, 1'b1}, r);
			i_scs_mst.bits({d, 1'b1}, r);
		end
		i_scs_mst.stop();
	endtask
	// Two bytes: ACK after the first, NACK after the second
	task automatic rd();
		i_scs_mst.start();
		i_scs_mst.bits({ad, 2'b01}, r);
		i_scs_mst.bits({oh, o, 1'b1}, r);
		i_scs_mst.start();
		i_scs_mst.bits({ad, 2'b11}, r);
		i_scs_mst.bits(9'h1fe, r);
		rb = r[8:1];
		i_scs_mst.bits(9'h1ff, r);
		i_scs_mst.stop();
	endtask
	// Offsets past the last byte read as zero
	function automatic logic [7:0] exp_rd(input logic [7:0] off);
		exp_rd = (off < 8'h10) ? mem[off[3:0]] : 8'h00;
	endfunction
	initial begin
		repeat (90000) @(posedge clk);
		bad_count++;
		stop_test();
	end
	initial begin
		srst = 1'b1;
		por_rst = 1'b1;
		ce = 1'b1;
		oh = 4'h0;
		fset = '0;
		void'($urandom(32'hbe05_0680));
		sa = 3'($urandom);
		strap = sa;
		ad = {4'hD, sa};
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		por_rst <= 1'b0;
		strap <= ~sa;
		fset <= 32'hffff_ffff;
		@(posedge clk);
		fset <= '0;
		repeat (4) @(posedge clk);
		for (int i = 0; i < 16; i++) begin
			mem[i] = (i inside {[8:11]}) ? 8'hff : 8'h00;
			chk(cfg[i*8+:8], mem[i]);
		end
		o = 4'h0;
		d = 8'h5a;
		for (int k = 0; k < 3; k++) begin
			wr(k == 0 ? {4'h3, sa} : {4'hD, sa ^ (k == 1 ? 3'h7 : 3'h1)});
			chk({7'h0, r[0]}, 8'h01);
		end
		for (int i = 0; i < 48; i++) begin
			o = (i < 16) ? 4'(i) : 4'($urandom);
			oh = (i % 12 == 5) ? 4'($urandom) | 4'h1 : 4'h0;
			d = 8'($urandom);
			wr(ad);
			chk({7'h0, r[0]}, 8'h00);
			if (oh == 4'h0)
				mem[o] = (o inside {[8:11]}) ? mem[o] & ~d : d;
			rd();
			chk(rb, exp_rd({oh, o}));
			chk(r[8:1], exp_rd({oh, o} + 8'h01));
			chk(cfg[o*8+:8], mem[o]);
		end
		ce <= 1'b0;
		fset <= 32'hffff_ffff;
		repeat (3) @(posedge clk);
		fset <= '0;
		ce <= 1'b1;
		repeat (2) @(posedge clk);
		for (int i = 8; i < 12; i++) chk(cfg[i*8+:8], mem[i]);
		srst <= 1'b1;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		for (int i = 0; i < 16; i++) chk(cfg[i*8+:8], i < 10 ? 8'h00 : mem[i]);
		chk(stalls, 8'h00);
		stop_test();
	end
endmodule
